// *** src/pin_map_pkg.sv ***
// pin map lock guard: shared constants, register map, key states
// assumes an 8-bit register port on the system clock, one map register per address
package pin_map_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] A_LOCK      = 8'h00;
    localparam logic [7:0] A_KEY       = 8'h01;
    localparam logic [7:0] A_IRQ_STAT  = 8'h02;
    localparam logic [7:0] A_IRQ_MASK  = 8'h03;
    localparam logic [7:0] A_STATUS    = 8'h04;
    localparam logic [7:0] A_IN_BASE   = 8'h20;
    localparam logic [7:0] A_OUT_BASE  = 8'h40;

    // ************************************************************
    // fields and reset values
    // ************************************************************
    localparam int         MAP_W       = 5;
    localparam logic [4:0] IN_MAP_RST  = 5'h1F;
    localparam logic [4:0] OUT_MAP_RST = 5'h00;
    localparam logic [7:0] KEY_FIRST   = 8'h55;
    localparam logic [7:0] KEY_SECOND  = 8'hAA;
    localparam int         LOCK_BIT    = 0;
    localparam logic       LOCK_RST    = 1'b0;
    localparam logic       FUSE_RST    = 1'b1;

    // event bits of status and mask
    localparam int EV_BLOCKED  = 0;
    localparam int EV_REFUSED  = 1;
    localparam int EV_LOCKCHG  = 2;
    localparam int EV_MISMATCH = 3;
    localparam int EV_W        = 4;

    // status register bits
    localparam int ST_LOCK     = 0;
    localparam int ST_FUSE     = 1;
    localparam int ST_ONCE     = 2;
    localparam int ST_MISMATCH = 3;
    localparam int ST_ARMED    = 4;

    typedef enum logic [2:0] {
        KEY_IDLE  = 3'b001,
        KEY_HALF  = 3'b010,
        KEY_ARMED = 3'b100
    } key_state_t;

endpackage

// *** src/map_reg_cell.sv ***
// one map register with its shadow copy
// assumes write enable already qualified by the lock
`timescale 1ns/1ns
`default_nettype none
module map_reg_cell #(
    parameter int         W   = 5,
    parameter logic [4:0] RST = 5'h00
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic         we_i,
    input  wire logic [W-1:0] wdata_i,
    output logic      [W-1:0] value_o,
    output logic              mismatch_o
);
    logic [W-1:0] value_q;
    logic [W-1:0] shadow_q;

    // live copy and shadow load together, so only an upset splits them
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            value_q  <= RST[W-1:0];
            shadow_q <= RST[W-1:0];
        end else if (we_i) begin
            value_q  <= wdata_i;
            shadow_q <= wdata_i;
        end
    end

    assign value_o    = value_q;
    assign mismatch_o = (value_q != shadow_q);
endmodule
`default_nettype wire

// *** src/pin_map_lock_guard.sv ***
// pin map lock guard: map registers, key sequence, lock, fuse, fabric
// assumes one 20 MHz clock, async high reset, single-strobe register port
`timescale 1ns/1ns
`default_nettype none
module pin_map_lock_guard #(
    parameter int N_IN   = 8,
    parameter int N_PINS = 32,
    parameter int N_FN   = 8
) (
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    input  wire logic [7:0]        addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [7:0]        rdata_o,
    input  wire logic              single_session_fuse_i,
    input  wire logic [N_PINS-1:0] pin_in_i,
    input  wire logic [N_FN-1:0]   periph_out_i,
    output logic      [N_IN-1:0]   periph_in_o,
    output logic      [N_PINS-1:0] pin_out_o,
    output logic      [N_PINS-1:0] pin_oe_o,
    output logic                   map_lock_o,
    output logic                   cfg_mismatch_reset_o,
    output logic                   irq_o
);

    // ************************************************************
    // declarations
    // ************************************************************
    localparam logic [7:0] IN_END  = 8'(pin_map_pkg::A_IN_BASE + N_IN);
    localparam logic [7:0] OUT_END = 8'(pin_map_pkg::A_OUT_BASE + N_PINS);

    pin_map_pkg::key_state_t key_q;
    pin_map_pkg::key_state_t key_d;

    logic                       map_lock_q;
    logic                       locked_once_q;
    logic                       fuse_meta_q;
    logic                       fuse_q;
    logic [N_PINS-1:0]          pin_meta_q;
    logic [N_PINS-1:0]          pin_q;
    logic [N_IN-1:0][4:0]       in_map;
    logic [N_PINS-1:0][4:0]     out_map;
    logic [N_IN-1:0]            in_mis;
    logic [N_PINS-1:0]          out_mis;
    logic [N_IN-1:0]            periph_in_d;
    logic [N_PINS-1:0]          pin_out_d;
    logic [pin_map_pkg::EV_W-1:0] stat_q;
    logic [pin_map_pkg::EV_W-1:0] mask_q;
    logic [pin_map_pkg::EV_W-1:0] ev;
    logic [7:0]                 rdata_q;
    logic [7:0]                 rdata_d;
    logic [7:0]                 in_idx;
    logic [7:0]                 out_idx;
    logic                       in_hit;
    logic                       out_hit;
    logic                       map_hit;
    logic                       wr_lock;
    logic                       accept;
    logic                       refuse;
    logic                       any_mis;
    logic                       mis_q;

    // ************************************************************
    // address decode
    // ************************************************************
    assign in_hit  = (addr_i >= pin_map_pkg::A_IN_BASE) && (addr_i < IN_END);
    assign out_hit = (addr_i >= pin_map_pkg::A_OUT_BASE) && (addr_i < OUT_END);
    assign map_hit = in_hit || out_hit;
    assign in_idx  = addr_i - pin_map_pkg::A_IN_BASE;
    assign out_idx = addr_i - pin_map_pkg::A_OUT_BASE;
    assign wr_lock = wr_i && (addr_i == pin_map_pkg::A_LOCK);

    // ************************************************************
    // fuse synchroniser
    // ************************************************************
    // the fuse line is static but arrives from outside; resets to the safe one-session value
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            fuse_meta_q <= pin_map_pkg::FUSE_RST;
            fuse_q      <= pin_map_pkg::FUSE_RST;
        end else begin
            fuse_meta_q <= single_session_fuse_i;
            fuse_q      <= fuse_meta_q;
        end
    end

    // ************************************************************
    // key sequence
    // ************************************************************
    // any access other than the expected one drops the sequence, except a first key write, which leaves it half
    always_comb begin
        key_d = key_q;
        if (wr_i || rd_i) begin
            case (key_q)
                pin_map_pkg::KEY_IDLE: begin
                    if (wr_i && addr_i == pin_map_pkg::A_KEY && wdata_i == pin_map_pkg::KEY_FIRST) begin
                        key_d = pin_map_pkg::KEY_HALF;
                    end
                end
                pin_map_pkg::KEY_HALF: begin
                    if (wr_i && addr_i == pin_map_pkg::A_KEY && wdata_i == pin_map_pkg::KEY_SECOND) begin
                        key_d = pin_map_pkg::KEY_ARMED;
                    end else if (wr_i && addr_i == pin_map_pkg::A_KEY
                                 && wdata_i == pin_map_pkg::KEY_FIRST) begin
                        key_d = pin_map_pkg::KEY_HALF;
                    end else begin
                        key_d = pin_map_pkg::KEY_IDLE;
                    end
                end
                pin_map_pkg::KEY_ARMED: begin
                    // armed state lasts for exactly one access
                    if (wr_i && addr_i == pin_map_pkg::A_KEY && wdata_i == pin_map_pkg::KEY_FIRST) begin
                        key_d = pin_map_pkg::KEY_HALF;
                    end else begin
                        key_d = pin_map_pkg::KEY_IDLE;
                    end
                end
                default: begin
                    key_d = pin_map_pkg::KEY_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            key_q <= pin_map_pkg::KEY_IDLE;
        end else begin
            key_q <= key_d;
        end
    end

    // ************************************************************
    // map lock
    // ************************************************************
    assign accept = wr_lock && (key_q == pin_map_pkg::KEY_ARMED);
    // one-session fuse: once locked, a clear is refused until reset
    assign refuse = wr_lock && (!accept || (fuse_q && locked_once_q
                    && !wdata_i[pin_map_pkg::LOCK_BIT]));

    // lock holds its value between accepted changes
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            map_lock_q <= pin_map_pkg::LOCK_RST;
        end else if (accept && !refuse) begin
            map_lock_q <= wdata_i[pin_map_pkg::LOCK_BIT];
        end
    end

    // remembers the first lock; only reset forgets it
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            locked_once_q <= 1'b0;
        end else if (map_lock_q) begin
            locked_once_q <= 1'b1;
        end
    end

    assign map_lock_o = map_lock_q;

    // ************************************************************
    // map registers with shadows
    // ************************************************************
    // writes while locked are dropped but the bus never sees an error
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_in
            map_reg_cell #(
                .W   (pin_map_pkg::MAP_W),
                .RST (pin_map_pkg::IN_MAP_RST)
            ) u_cell (
                .mclk_i     (mclk_i),
                .rst_i      (rst_i),
                .we_i       (wr_i && in_hit && !map_lock_q && in_idx == 8'(gi)),
                .wdata_i    (wdata_i[4:0]),
                .value_o    (in_map[gi]),
                .mismatch_o (in_mis[gi])
            );
        end
        for (gi = 0; gi < N_PINS; gi++) begin : g_out
            map_reg_cell #(
                .W   (pin_map_pkg::MAP_W),
                .RST (pin_map_pkg::OUT_MAP_RST)
            ) u_cell (
                .mclk_i     (mclk_i),
                .rst_i      (rst_i),
                .we_i       (wr_i && out_hit && !map_lock_q && out_idx == 8'(gi)),
                .wdata_i    (wdata_i[4:0]),
                .value_o    (out_map[gi]),
                .mismatch_o (out_mis[gi])
            );
        end
    endgenerate

    // ************************************************************
    // continuous monitoring
    // ************************************************************
    assign any_mis = (|in_mis) || (|out_mis);

    // registered so the reset request is glitch free
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mis_q <= 1'b0;
        end else begin
            mis_q <= any_mis;
        end
    end

    assign cfg_mismatch_reset_o = mis_q;

    // ************************************************************
    // pin synchroniser and mapping fabric
    // ************************************************************
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta_q <= '0;
            pin_q      <= '0;
        end else begin
            pin_meta_q <= pin_in_i;
            pin_q      <= pin_meta_q;
        end
    end

    // one source per peripheral input; a selector past the last pin reads zero
    always_comb begin
        periph_in_d = '0;
        for (int i = 0; i < N_IN; i++) begin
            for (int p = 0; p < N_PINS; p++) begin
                if (in_map[i] == 5'(p)) begin
                    periph_in_d[i] = pin_q[p];
                end
            end
        end
    end

    // one code per pin, so two outputs can never fight on a pin
    always_comb begin
        pin_out_d = '0;
        for (int p = 0; p < N_PINS; p++) begin
            for (int f = 0; f < N_FN; f++) begin
                if (out_map[p] == 5'(f + 1)) begin
                    pin_out_d[p] = periph_out_i[f];
                end
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            periph_in_o <= '0;
            pin_out_o   <= '0;
            pin_oe_o    <= '0;
        end else begin
            periph_in_o <= periph_in_d;
            pin_out_o   <= pin_out_d;
            for (int p = 0; p < N_PINS; p++) begin
                pin_oe_o[p] <= (out_map[p] != pin_map_pkg::OUT_MAP_RST);
            end
        end
    end

    // ************************************************************
    // events and interrupt
    // ************************************************************
    always_comb begin
        ev = '0;
        ev[pin_map_pkg::EV_BLOCKED]  = wr_i && map_hit && map_lock_q;
        ev[pin_map_pkg::EV_REFUSED]  = refuse;
        ev[pin_map_pkg::EV_LOCKCHG]  = accept && !refuse
                                       && (wdata_i[pin_map_pkg::LOCK_BIT] != map_lock_q);
        ev[pin_map_pkg::EV_MISMATCH] = any_mis;
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_q <= '0;
        end else if (wr_i && addr_i == pin_map_pkg::A_IRQ_STAT) begin
            stat_q <= (stat_q & ~wdata_i[pin_map_pkg::EV_W-1:0]) | ev;
        end else begin
            stat_q <= stat_q | ev;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_q <= '0;
        end else if (wr_i && addr_i == pin_map_pkg::A_IRQ_MASK) begin
            mask_q <= wdata_i[pin_map_pkg::EV_W-1:0];
        end
    end

    assign irq_o = |(stat_q & mask_q);

    // ************************************************************
    // read path
    // ************************************************************
    // unmapped addresses read zero; reads have no side effect beyond the key reset
    always_comb begin
        rdata_d = 8'h00;
        if (addr_i == pin_map_pkg::A_LOCK) begin
            rdata_d[pin_map_pkg::LOCK_BIT] = map_lock_q;
        end else if (addr_i == pin_map_pkg::A_IRQ_STAT) begin
            rdata_d[pin_map_pkg::EV_W-1:0] = stat_q;
        end else if (addr_i == pin_map_pkg::A_IRQ_MASK) begin
            rdata_d[pin_map_pkg::EV_W-1:0] = mask_q;
        end else if (addr_i == pin_map_pkg::A_STATUS) begin
            rdata_d[pin_map_pkg::ST_LOCK]     = map_lock_q;
            rdata_d[pin_map_pkg::ST_FUSE]     = fuse_q;
            rdata_d[pin_map_pkg::ST_ONCE]     = locked_once_q;
            rdata_d[pin_map_pkg::ST_MISMATCH] = mis_q;
            rdata_d[pin_map_pkg::ST_ARMED]    = (key_q == pin_map_pkg::KEY_ARMED);
        end else if (in_hit) begin
            rdata_d[4:0] = in_map[in_idx[$clog2(N_IN)-1:0]];
        end else if (out_hit) begin
            rdata_d[4:0] = out_map[out_idx[$clog2(N_PINS)-1:0]];
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else if (rd_i) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata_o = rdata_q;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_key_first;
        wr_i && addr_i == pin_map_pkg::A_KEY && wdata_i == pin_map_pkg::KEY_FIRST;
    endsequence

    sequence s_key_second;
        wr_i && addr_i == pin_map_pkg::A_KEY && wdata_i == pin_map_pkg::KEY_SECOND;
    endsequence

    sequence s_unlock;
        s_key_first ##1 s_key_second ##1 (wr_lock
            && !(fuse_q && locked_once_q && !wdata_i[pin_map_pkg::LOCK_BIT]));
    endsequence

    property p_blocked_write;
        map_lock_q && wr_i && map_hit |=> $stable(in_map) && $stable(out_map);
    endproperty
    a_blocked_write: assert property (p_blocked_write) else $error("locked map write changed a map");

    property p_lock_read;
        rd_i && addr_i == pin_map_pkg::A_LOCK |=> rdata_o[0] == $past(map_lock_q);
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock bit read wrong");

    property p_key_accept;
        s_unlock |=> map_lock_q == $past(wdata_i[0]);
    endproperty
    a_key_accept: assert property (p_key_accept) else $error("key sequence did not change lock");

    property p_map_write;
        !map_lock_q && wr_i && addr_i == pin_map_pkg::A_IN_BASE |=> in_map[0] == $past(wdata_i[4:0]);
    endproperty
    a_map_write: assert property (p_map_write) else $error("unlocked map write lost");

    property p_mismatch;
        any_mis |=> cfg_mismatch_reset_o;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch did not request reset");

    property p_one_session;
        fuse_q && locked_once_q && map_lock_q |=> map_lock_q [*2];
    endproperty
    a_one_session: assert property (p_one_session) else $error("one-session lock was cleared");

    property p_change_cause;
        !$stable(map_lock_q) |-> $past(key_q) == pin_map_pkg::KEY_ARMED && $past(wr_lock);
    endproperty
    a_change_cause: assert property (p_change_cause) else $error("lock changed without key");

    property p_reset_maps;
        $past(rst_i) |-> (&in_map) && out_map == '0 && !map_lock_q;
    endproperty
    a_reset_maps: assert property (p_reset_maps) else $error("map reset values wrong");

    property p_blocked_flag;
        map_lock_q && wr_i && map_hit |=> stat_q[pin_map_pkg::EV_BLOCKED];
    endproperty
    a_blocked_flag: assert property (p_blocked_flag) else $error("blocked write not flagged");

endmodule
`default_nettype wire

// *** tb/pin_map_lock_guard_tb_top.sv ***
// testbench for the pin map lock guard: register bus tasks, scenarios, verdict
// assumes the guard's default parameters and the register map of its package
`timescale 1ns/1ns
`default_nettype none
module pin_map_lock_guard_tb_top;
    logic        mclk_i  = 1'b0;
    logic        rst_i   = 1'b1;
    logic [7:0]  addr_i  = 8'h00;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i    = 1'b0;
    logic        rd_i    = 1'b0;
    logic        fuse    = 1'b1;
    logic [31:0] pin_in  = 32'h00000000;
    logic [7:0]  pout    = 8'h00;
    logic [7:0]  rdata;
    logic [7:0]  periph_in;
    logic [31:0] pin_out;
    logic [31:0] pin_oe;
    logic        lock;
    logic        mism;
    logic        irq;
    int          mismatches = 0;
    int          tests_run  = 0;
    logic [7:0]  d;

    pin_map_lock_guard dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata), .single_session_fuse_i(fuse), .pin_in_i(pin_in), .periph_out_i(pout),
        .periph_in_o(periph_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe), .map_lock_o(lock),
        .cfg_mismatch_reset_o(mism), .irq_o(irq)
    );

    // 20 MHz system clock
    initial begin
        forever #25 mclk_i = ~mclk_i;
    end

    // ************************************************************
    // bus tasks
    // ************************************************************
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // strobes stay up between transfers so no signal is assigned twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        rd_i    <= 1'b0;
        @(posedge mclk_i);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        addr_i <= a;
        rd_i   <= 1'b1;
        wr_i   <= 1'b0;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 v = rdata;
        @(posedge mclk_i);
    endtask

    task automatic idle(input int n);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        idle(2);
        rst_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    // key pair then the lock write, back to back
    task automatic key(input logic [7:0] v);
        wr(8'h01, 8'h55);
        wr(8'h01, 8'hAA);
        wr(8'h00, v);
        idle(2);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            rd(8'h20 + 8'(i), d);
            check("in_map", 8'h1F, d);
        end
        rd(8'h40, d);
        check("out_map_first", 8'h00, d);
        rd(8'h5F, d);
        check("out_map_last", 8'h00, d);
        rd(8'h00, d);
        check("lock_ctrl", 8'h00, d);
        rd(8'h08, d);
        check("unmapped", 8'h00, d);
        pin_in <= 32'h80000000;
        idle(5);
        check("periph_in_pin31", 8'hFF, periph_in);
        check("oe_low", 8'h00, pin_oe[7:0]);
    endtask

    // two inputs share one pin, one output drives two pins
    task automatic t_fanout();
        wr(8'h20, 8'h05);
        wr(8'h21, 8'h05);
        wr(8'h42, 8'h01);
        wr(8'h43, 8'h01);
        pin_in <= 32'h00000020;
        pout   <= 8'h01;
        idle(5);
        check("periph_in_shared", 8'h03, {6'h00, periph_in[1:0]});
        check("pin_out_shared", 8'h0C, pin_out[7:0]);
        check("pin_oe_shared", 8'h0C, pin_oe[7:0]);
        rd(8'h20, d);
        check("map_unlocked", 8'h05, d);
    endtask

    // single session: lock once, then clearing is refused
    task automatic t_lock_once();
        key(8'h01);
        check("lock_set", 8'h01, 8'(lock));
        rd(8'h00, d);
        check("lock_bit0", 8'h01, d);
        wr(8'h20, 8'h0A);
        idle(1);
        rd(8'h20, d);
        check("map_kept", 8'h05, d);
        rd(8'h02, d);
        check("blocked_flag", 8'h01, d & 8'h01);
        check("lockchg_flag", 8'h04, d & 8'h04);
        check("irq_masked", 8'h00, 8'(irq));
        wr(8'h03, 8'h01);
        idle(1);
        check("irq_raised", 8'h01, 8'(irq));
        wr(8'h02, 8'h01);
        idle(1);
        check("irq_cleared", 8'h00, 8'(irq));
        key(8'h00);
        check("clear_refused", 8'h01, 8'(lock));
        rd(8'h02, d);
        check("refused_flag", 8'h02, d & 8'h02);
        wr(8'h21, 8'h0A);
        idle(1);
        rd(8'h21, d);
        check("map_still_kept", 8'h05, d);
        rd(8'h04, d);
        check("status_once", 8'h07, d);
    endtask

    // only a device reset clears a once-set lock
    task automatic t_reset_clears();
        do_reset();
        check("lock_after_reset", 8'h00, 8'(lock));
        wr(8'h20, 8'h03);
        idle(1);
        rd(8'h20, d);
        check("map_after_reset", 8'h03, d);
    endtask

    // programmed fuse: repeated lock cycles, several writes per unlock
    task automatic t_unlimited();
        fuse <= 1'b0;
        idle(3);
        for (int i = 0; i < 2; i++) begin
            key(8'h01);
            check("relock", 8'h01, 8'(lock));
            key(8'h00);
            check("reunlock", 8'h00, 8'(lock));
        end
        wr(8'h22, 8'h01);
        wr(8'h23, 8'h02);
        rd(8'h22, d);
        check("multi_write_a", 8'h01, d);
        rd(8'h23, d);
        check("multi_write_b", 8'h02, d);
    endtask

    // an access between the steps cancels the sequence
    task automatic t_cancel();
        wr(8'h01, 8'h55);
        rd(8'h04, d);
        wr(8'h01, 8'hAA);
        wr(8'h00, 8'h01);
        idle(2);
        check("read_cancels", 8'h00, 8'(lock));
        wr(8'h01, 8'h55);
        wr(8'h01, 8'hAA);
        wr(8'h20, 8'h07);
        wr(8'h00, 8'h01);
        idle(2);
        check("write_cancels", 8'h00, 8'(lock));
        wr(8'h01, 8'h55);
        wr(8'h01, 8'hAA);
        rd(8'h04, d);
        check("armed_status", 8'h14, d);
        wr(8'h00, 8'h01);
        idle(2);
        check("armed_read_cancels", 8'h00, 8'(lock));
        check("no_mismatch", 8'h00, 8'(mism));
    endtask

    task automatic summarize();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #200000;
        mismatches++;
        summarize();
    end

    initial begin
        do_reset();
        t_reset();
        t_fanout();
        t_lock_once();
        t_reset_clears();
        t_unlimited();
        t_cancel();
        summarize();
    end
endmodule
`default_nettype wire
